// ### dcc_top.sv
// dual comparator control: registers, mismatch flag, pin routing
`timescale 1ns/1ns
module dcc_top
   import dcc_pkg::*;
#(
   parameter logic [63:0] ROUTE_TABLE = ROUTE_TABLE_RST
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_sys_rst,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rdata,
   input  wire logic              i_cmp1_raw,
   input  wire logic              i_cmp2_raw,
   input  wire logic [NPIN-1:0]   i_porta_pin,
   output logic      [NPIN-1:0]   o_porta_pin,
   output logic      [NPIN-1:0]   o_porta_pin_oe_n,
   output logic      [NPIN-1:0]   o_pin_analog,
   output logic                   o_cmp1_neg_pin3,
   output logic                   o_cmp2_neg_pin2,
   output logic                   o_vref_to_pos,
   output logic                   o_vref_to_pin2,
   output logic                   o_cmp_power,
   output logic                   o_cmp_irq
);
   //-------------------------------------------------------------------------
   // decoding
   //-------------------------------------------------------------------------
   function automatic logic [7:0] route_of(input logic [2:0] mode);
      route_of = ROUTE_TABLE[{mode, 3'h0} +: 8];
   endfunction : route_of

   logic [DATA_W-1:0] ctrl_q;
   logic              flag_q;
   logic [2:0]        irq_en_q;
   logic [NPIN-1:0]   dir_q;
   logic [NPIN-1:0]   latch_q;
   logic              vref_oe_q;
   logic [1:0]        snap_q;
   logic [DATA_W-1:0] rdata_q;
   logic              irq_q;
   logic [NPIN-1:0]   pin_oe_n_q;
   logic [NPIN-1:0]   pin_ana_q;
   logic [NPIN-1:0]   pin_dat_q;
   logic [4:0]        mux_q;

   logic [1:0]      raw_s;
   logic [NPIN-1:0] pin_s;
   logic [1:0]      result;
   logic [2:0]      mode;
   logic [7:0]      route;
   logic            vref_mode;
   logic            ctrl_acc;
   logic            mismatch;
   logic [NPIN-1:0] ana_mask;
   logic [NPIN-1:0] port_rd;

   dcc_sync2 #(.W(2)) u_cmp_sync (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst),
      .i_async   ({i_cmp2_raw, i_cmp1_raw}),
      .o_sync    (raw_s)
   );

   dcc_sync2 #(.W(NPIN)) u_pin_sync (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst),
      .i_async   (i_porta_pin),
      .o_sync    (pin_s)
   );

   assign mode      = ctrl_q[CTRL_MODE_H:0];
   assign route     = route_of(mode);
   assign vref_mode = (mode == MODE_VREF);
   // inversion applies after the synchroniser so it never glitches the first flop
   assign result[1] = raw_s[1] ^ ctrl_q[CTRL_C2_INV];
   assign result[0] = raw_s[0] ^ ctrl_q[CTRL_C1_INV];
   assign ctrl_acc  = (i_wr || i_rd) && (i_addr == ADDR_CTRL);
   assign mismatch  = (result != snap_q);
   // mode 110 leaves comparator pins to their direction bits
   assign ana_mask  = vref_mode ? '0 : route[NPIN-1:0];
   assign port_rd   = pin_s & ~ana_mask;

   //-------------------------------------------------------------------------
   // control register
   //-------------------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl_q <= CTRL_RST;
      end else begin
         // result bits are stored from live results, never from the bus
         ctrl_q[CTRL_C2_RES:CTRL_C1_RES] <= result;
         if (i_wr && i_addr == ADDR_CTRL) begin
            ctrl_q[CTRL_C2_INV:0] <= i_wdata[CTRL_C2_INV:0];
         end
      end
   end

   // snapshot of results on every control access ends the mismatch
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         snap_q <= 2'h0;
      end else if (ctrl_acc) begin
         snap_q <= result;
      end
   end

   //-------------------------------------------------------------------------
   // interrupt flag and request
   //-------------------------------------------------------------------------
   // a hardware set wins over a software clear in the same cycle; a change
   // caught during a control read is snapshotted and so may not set the flag
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         flag_q <= 1'b0;
      end else if (mismatch && !ctrl_acc) begin
         flag_q <= 1'b1;
      end else if (i_wr && i_addr == ADDR_IRQ) begin
         flag_q <= i_wdata[IRQ_FLAG];
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         irq_en_q <= 3'h0;
      end else if (i_wr && i_addr == ADDR_IRQ) begin
         irq_en_q <= i_wdata[IRQ_GLBE:IRQ_CMPE];
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= flag_q && (&irq_en_q);
      end
   end

   //-------------------------------------------------------------------------
   // port direction, latch, vref pin switch
   //-------------------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         dir_q     <= DIR_RST;
         latch_q   <= LATCH_RST;
         vref_oe_q <= 1'b0;
      end else if (i_wr) begin
         if (i_addr == ADDR_DIR) begin
            dir_q <= i_wdata[NPIN-1:0];
         end
         if (i_addr == ADDR_LATCH) begin
            latch_q <= i_wdata[NPIN-1:0];
         end
         if (i_addr == ADDR_VREF) begin
            vref_oe_q <= i_wdata[VREF_PIN_OE];
         end
      end
   end

   //-------------------------------------------------------------------------
   // read data, one cycle after the strobe
   //-------------------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rdata_q <= 8'h00;
      end else if (i_rd) begin
         unique case (i_addr)
            ADDR_CTRL:  rdata_q <= {result, ctrl_q[CTRL_C2_INV:0]};
            ADDR_IRQ:   rdata_q <= {4'h0, irq_en_q, flag_q};
            ADDR_DIR:   rdata_q <= {2'h0, dir_q};
            ADDR_LATCH: rdata_q <= {2'h0, latch_q};
            ADDR_PORT:  rdata_q <= {2'h0, port_rd};
            ADDR_VREF:  rdata_q <= {1'b0, vref_oe_q, 6'h00};
            default:    rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   //-------------------------------------------------------------------------
   // pin drivers and analog switches
   //-------------------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pin_oe_n_q <= '1;
         pin_ana_q  <= 6'h0F;
         pin_dat_q  <= '0;
      end else begin
         for (int i = 0; i < NPIN; i++) begin
            // analog assignment overrides direction; vref on pin 2 also blocks the driver
            pin_oe_n_q[i] <= ana_mask[i] | dir_q[i] | ((i == 2) & vref_oe_q);
         end
         // pin 4 keeps obeying its direction bit; software must make it an output
         pin_oe_n_q[4] <= ana_mask[4] | dir_q[4];
         if (route[RT_CMP2_RESULT] && !vref_mode) begin
            pin_oe_n_q[5] <= 1'b0;
         end
         pin_ana_q <= route[NPIN-1:0];
         pin_dat_q <= latch_q;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mux_q <= 5'h00;
      end else begin
         mux_q[0] <= vref_mode && ctrl_q[CTRL_ISW];
         mux_q[1] <= vref_mode && ctrl_q[CTRL_ISW];
         mux_q[2] <= vref_mode;
         mux_q[3] <= vref_oe_q;
         mux_q[4] <= (mode != MODE_OFF);
      end
   end

   // pins 4 and 5 bypass every flop when routed: the raw result, xored with its inversion bit, goes straight out
   always_comb begin
      o_porta_pin = pin_dat_q;
      if (route[RT_CMP1_RESULT]) begin
         o_porta_pin[4] = i_cmp1_raw ^ ctrl_q[CTRL_C1_INV];
      end
      if (route[RT_CMP2_RESULT]) begin
         o_porta_pin[5] = i_cmp2_raw ^ ctrl_q[CTRL_C2_INV];
      end
   end

   assign o_rdata          = rdata_q;
   assign o_porta_pin_oe_n = pin_oe_n_q;
   assign o_pin_analog     = pin_ana_q;
   assign o_cmp1_neg_pin3  = mux_q[0];
   assign o_cmp2_neg_pin2  = mux_q[1];
   assign o_vref_to_pos    = mux_q[2];
   assign o_vref_to_pin2   = mux_q[3];
   assign o_cmp_power      = mux_q[4];
   assign o_cmp_irq        = irq_q;

   //-------------------------------------------------------------------------
   // assertions: control register and results
   //-------------------------------------------------------------------------
   mode_reset_a: assert property (@(posedge i_ref_clk) $fell(i_sys_rst) |-> mode == MODE_OFF)
      else $error("mode not 111 after reset");

   power_off_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      mode == MODE_OFF |=> !o_cmp_power)
      else $error("comparators powered in off mode");

   ctrl_wr_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_wr && i_addr == ADDR_CTRL |=> ctrl_q[CTRL_C2_INV:0] == $past(i_wdata[CTRL_C2_INV:0]))
      else $error("control write lost");

   res_wr_ro_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_wr && i_addr == ADDR_CTRL |=> ctrl_q[CTRL_C2_RES:CTRL_C1_RES] == $past(result))
      else $error("write reached result bits");

   result_ro_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_rd && i_addr == ADDR_CTRL |=> o_rdata[CTRL_C2_RES:CTRL_C1_RES] == $past(result))
      else $error("result bits not read back");

   // three samples back: two synchroniser flops, then the read cycle itself
   res1_inv_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_rd && i_addr == ADDR_CTRL |=> o_rdata[CTRL_C1_RES] == ($past(i_cmp1_raw, 3) ^ $past(ctrl_q[CTRL_C1_INV])))
      else $error("cmp1 result polarity wrong");

   res2_inv_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_rd && i_addr == ADDR_CTRL |=> o_rdata[CTRL_C2_RES] == ($past(i_cmp2_raw, 3) ^ $past(ctrl_q[CTRL_C2_INV])))
      else $error("cmp2 result polarity wrong");

   //-------------------------------------------------------------------------
   // assertions: interrupt flag and request
   //-------------------------------------------------------------------------
   flag_set_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      mismatch && !ctrl_acc |=> flag_q)
      else $error("flag not set on change");

   flag_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      flag_q && !(i_wr && i_addr == ADDR_IRQ) |=> flag_q)
      else $error("flag cleared without software");

   flag_sw_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_wr && i_addr == ADDR_IRQ && !mismatch |=> flag_q == $past(i_wdata[IRQ_FLAG]))
      else $error("software flag write lost");

   // a change met by a control access is absorbed into the snapshot, not flagged
   flag_miss_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      ctrl_acc && !flag_q |=> !flag_q)
      else $error("flag set during control access");

   mismatch_end_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      ctrl_acc && !i_wr ##1 $stable(raw_s) |-> !mismatch)
      else $error("access did not end mismatch");

   res_cap_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      ctrl_acc |=> mismatch == $changed(result))
      else $error("results not captured on access");

   irq_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_cmp_irq == $past(flag_q && (&irq_en_q)))
      else $error("irq request gating wrong");

   //-------------------------------------------------------------------------
   // assertions: pins and analog switches
   //-------------------------------------------------------------------------
   pin5_drive_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      route[RT_CMP2_RESULT] && !vref_mode ##1 $stable(mode) |-> !o_porta_pin_oe_n[5])
      else $error("pin 5 not driven");

   pin4_dir_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      route[RT_CMP1_RESULT] && !ana_mask[4] |=> o_porta_pin_oe_n[4] == $past(dir_q[4]))
      else $error("pin 4 ignores its direction bit");

   ana_read_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_rd && i_addr == ADDR_PORT |=> (o_rdata[NPIN-1:0] & $past(ana_mask)) == '0)
      else $error("analog pin read nonzero");

   // pin 5 is left out: a custom table may force it driven over an analog role
   ana_oe_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      !vref_mode |=> (~o_porta_pin_oe_n & $past(ana_mask) & 6'h1F) == 6'h00)
      else $error("analog pin driven");

   dig_oe_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      vref_mode && !vref_oe_q |=> o_porta_pin_oe_n == $past(dir_q))
      else $error("mode 110 pins do not follow direction");

   vref_pos_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      vref_mode |=> o_vref_to_pos)
      else $error("vref not on positive inputs");

   vref_off_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      !vref_mode |=> !o_vref_to_pos)
      else $error("vref on positive inputs outside mode 110");

   isw_on_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      vref_mode && ctrl_q[CTRL_ISW] |=> o_cmp1_neg_pin3 && o_cmp2_neg_pin2)
      else $error("negative inputs not switched");

   isw_off_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      !(vref_mode && ctrl_q[CTRL_ISW]) |=> !o_cmp1_neg_pin3 && !o_cmp2_neg_pin2)
      else $error("negative inputs switched unasked");

   cv_flag_c:   cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) $rose(flag_q));
   cv_irq_c:    cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) $rose(o_cmp_irq));
   cv_vref_c:   cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) vref_mode && ctrl_q[CTRL_ISW]);
   cv_route_c:  cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) route[RT_CMP2_RESULT] && !o_porta_pin_oe_n[5]);
   cv_masked_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) $rose(flag_q) && !(&irq_en_q));
endmodule : dcc_top

// ### dcc_pkg.sv
// constants, register map and field layout of the dual comparator control block
//----------------------------------------------------------------------------
//----------------------------------------------------------------------------
package dcc_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int NPIN   = 6;

   // register offsets
   localparam logic [ADDR_W-1:0] ADDR_CTRL  = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_IRQ   = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_DIR   = 3'h2;
   localparam logic [ADDR_W-1:0] ADDR_LATCH = 3'h3;
   localparam logic [ADDR_W-1:0] ADDR_PORT  = 3'h4;
   localparam logic [ADDR_W-1:0] ADDR_VREF  = 3'h5;

   // control register fields
   localparam int CTRL_C2_RES = 7;
   localparam int CTRL_C1_RES = 6;
   localparam int CTRL_C2_INV = 5;
   localparam int CTRL_C1_INV = 4;
   localparam int CTRL_ISW    = 3;
   localparam int CTRL_MODE_H = 2;

   // interrupt register fields
   localparam int IRQ_FLAG = 0;
   localparam int IRQ_CMPE = 1;
   localparam int IRQ_PERE = 2;
   localparam int IRQ_GLBE = 3;

   // vref config field
   localparam int VREF_PIN_OE = 6;

   // reset values
   localparam logic [DATA_W-1:0] CTRL_RST  = 8'h07;
   localparam logic [NPIN-1:0]   DIR_RST   = 6'h3F;
   localparam logic [NPIN-1:0]   LATCH_RST = 6'h00;

   localparam logic [2:0] MODE_VREF = 3'h6;
   localparam logic [2:0] MODE_OFF  = 3'h7;

   // routing table entry: [5:0] analog pin mask, [6] cmp1 to pin 4, [7] cmp2 to pin 5
   localparam int RT_CMP1_RESULT = 6;
   localparam int RT_CMP2_RESULT = 7;
   localparam logic [63:0] ROUTE_TABLE_RST = 64'h0F0F_430F_C30F_030F;
endpackage : dcc_pkg

// ### dcc_sync2.sv
// two-flop level synchroniser
`timescale 1ns/1ns
module dcc_sync2 #(
   parameter int W = 1
) (
   input  wire logic         i_ref_clk,
   input  wire logic         i_sys_rst,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // meta_q feeds only sync_q
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule : dcc_sync2

// ### dcc_analog_model.sv
// behavioural analog front end: pin voltages and internal reference into two comparators
`timescale 1ns/1ns
module dcc_analog_model (
   input  wire logic [31:0] i_lvl,
   input  wire logic [7:0]  i_vref,
   input  wire logic        i_power,
   input  wire logic        i_vref_to_pos,
   input  wire logic        i_neg_pin3,
   input  wire logic        i_neg_pin2,
   output logic             o_cmp1_raw,
   output logic             o_cmp2_raw
);
   //----------------------------------------------------------------------------
   // input selection and comparison
   //----------------------------------------------------------------------------
   logic [7:0] pos1;
   logic [7:0] pos2;
   logic [7:0] neg1;
   logic [7:0] neg2;
   assign pos1 = i_vref_to_pos ? i_vref : i_lvl[31:24];
   assign pos2 = i_vref_to_pos ? i_vref : i_lvl[23:16];
   assign neg1 = i_neg_pin3 ? i_lvl[31:24] : i_lvl[7:0];
   assign neg2 = i_neg_pin2 ? i_lvl[23:16] : i_lvl[15:8];
   // powered-down comparators give a low output, so the off mode is not kind to the design
   assign o_cmp1_raw = i_power & (pos1 > neg1);
   assign o_cmp2_raw = i_power & (pos2 > neg2);
endmodule : dcc_analog_model

// ### tb_dual_comparator_control.sv
// self-checking bench for the dual comparator control block
`timescale 1ns/1ns
module tb_dual_comparator_control
   import dcc_pkg::*;
;
   logic              i_ref_clk = 1'b0;
   logic              i_sys_rst = 1'b1;
   logic [ADDR_W-1:0] i_addr    = '0;
   logic [DATA_W-1:0] i_wdata   = '0;
   logic              i_wr      = 1'b0;
   logic              i_rd      = 1'b0;
   logic [DATA_W-1:0] o_rdata;
   logic              raw1;
   logic              raw2;
   logic [NPIN-1:0]   pin_ext   = 6'h3F;
   logic [NPIN-1:0]   pin_wire;
   logic [NPIN-1:0]   pin_out;
   logic [NPIN-1:0]   oe_n;
   logic [NPIN-1:0]   analog;
   logic              n3, n2, vpos, vpin2, power, irq;
   logic [31:0]       lvl       = 32'h2814_320A;
   logic [7:0]        vref      = 8'h1E;
   logic [7:0]        rv;
   int                failures  = 0;
   int                compares  = 0;

   always #20 i_ref_clk = ~i_ref_clk;
   // the wire follows whoever drives it; pins 4 and 5 may be driven by the block
   assign pin_wire = (oe_n & pin_ext) | (~oe_n & pin_out);

   dcc_top dut_u (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp1_raw(raw1), .i_cmp2_raw(raw2),
      .i_porta_pin(pin_wire), .o_porta_pin(pin_out), .o_porta_pin_oe_n(oe_n), .o_pin_analog(analog),
      .o_cmp1_neg_pin3(n3), .o_cmp2_neg_pin2(n2), .o_vref_to_pos(vpos), .o_vref_to_pin2(vpin2),
      .o_cmp_power(power), .o_cmp_irq(irq));
   dcc_analog_model model_u (.i_lvl(lvl), .i_vref(vref), .i_power(power), .i_vref_to_pos(vpos),
      .i_neg_pin3(n3), .i_neg_pin2(n2), .o_cmp1_raw(raw1), .o_cmp2_raw(raw2));

   //----------------------------------------------------------------------------
   // bus and compare helpers
   //----------------------------------------------------------------------------
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk_reg
   task automatic chk_pin(input logic got, input logic exp, input string msg);
      chk_reg({7'h00, got}, {7'h00, exp}, msg);
   endtask : chk_pin
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 rv = o_rdata;
   endtask : rd
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string msg);
      rd(a);
      chk_reg(rv, exp, msg);
   endtask : rd_chk
   task automatic idle(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask : idle
   task automatic complete_run();
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   //----------------------------------------------------------------------------
   // scenarios
   //----------------------------------------------------------------------------
   task automatic test_reset();
      chk_reg({2'b00, analog}, 8'h0F, "analog pins at reset");
      chk_pin(power, 1'b0, "comparators off at reset");
      rd_chk(ADDR_CTRL, 8'h07, "control reset");
      rd_chk(ADDR_DIR, 8'h3F, "direction reset");
      rd_chk(3'h7, 8'h00, "unmapped read");
      $display("test reset done");
   endtask : test_reset

   task automatic test_modes();
      for (int m = 0; m < 8; m++) begin
         wr(ADDR_CTRL, {5'h00, m[2:0]});
         idle(3);
         chk_reg({2'b00, analog}, {2'b00, ROUTE_TABLE_RST[m*8 +: 6]}, "mode routing");
         chk_pin(power, m != 7, "mode power");
      end
      $display("test modes done");
   endtask : test_modes

   task automatic test_result();
      wr(ADDR_CTRL, 8'h03);
      idle(5);
      rd_chk(ADDR_CTRL, 8'h43, "plain results");
      chk_pin(oe_n[5], 1'b0, "pin5 forced driven");
      chk_pin(oe_n[4], 1'b1, "pin4 obeys direction");
      wr(ADDR_CTRL, 8'hF3);
      idle(5);
      rd_chk(ADDR_CTRL, 8'hB3, "inverted, result bits read-only");
      chk_pin(pin_out[5], 1'b1, "pin5 carries result");
      wr(ADDR_DIR, 8'h00);
      idle(3);
      chk_pin(oe_n[4], 1'b0, "pin4 driven as output");
      chk_reg({6'h00, oe_n[1:0]}, 8'h03, "analog pins stay undriven");
      chk_pin(pin_out[4], 1'b0, "pin4 carries inverted result");
      @(negedge i_ref_clk);
      lvl[7:0] = 8'h3C;
      #1 chk_pin(pin_out[4], 1'b1, "pin4 follows raw output unclocked");
      lvl[7:0] = 8'h0A;
      wr(ADDR_DIR, 8'h3F);
      idle(4);
      rd(ADDR_PORT);
      chk_reg(rv & 8'h0F, 8'h0C, "analog pins read zero");
      $display("test result done");
   endtask : test_result

   task automatic test_vref();
      wr(ADDR_CTRL, 8'h06);
      idle(5);
      chk_pin(vpos, 1'b1, "reference on positive inputs");
      chk_pin(n3, 1'b0, "cmp1 negative on pin0");
      rd_chk(ADDR_CTRL, 8'h46, "results against reference");
      wr(ADDR_CTRL, 8'h0E);
      idle(5);
      chk_reg({6'h00, n3, n2}, 8'h03, "negative inputs switched");
      rd_chk(ADDR_CTRL, 8'h8E, "switched results");
      rd(ADDR_PORT);
      chk_reg(rv & 8'h0F, 8'h0F, "mode 110 pins read digital");
      wr(ADDR_LATCH, 8'h2A);
      wr(ADDR_DIR, 8'h00);
      wr(ADDR_VREF, 8'h40);
      idle(3);
      chk_pin(vpin2, 1'b1, "reference switched to pin2");
      chk_reg({2'b00, oe_n}, 8'h04, "mode 110 pins obey direction");
      chk_reg({2'b00, pin_out}, 8'h2A, "latch on pins");
      rd_chk(ADDR_VREF, 8'h40, "reference config readback");
      rd_chk(ADDR_PORT, 8'h2E, "mode 110 pins read own level");
      $display("test vref done");
   endtask : test_vref

   task automatic test_irq();
      int n;
      wr(ADDR_CTRL, 8'h03);
      idle(5);
      rd(ADDR_CTRL);
      wr(ADDR_IRQ, 8'h0E);
      rd_chk(ADDR_IRQ, 8'h0E, "flag cleared, enables set");
      lvl[7:0] = 8'h3C;
      n = 0;
      while (irq !== 1'b1 && n < 10) begin
         idle(1);
         n++;
      end
      if (n == 10) begin
         failures++;
         $display("CHECK FAILED %0t no interrupt request", $time);
         complete_run();
      end
      rd_chk(ADDR_IRQ, 8'h0F, "flag set on change");
      wr(ADDR_IRQ, 8'h0E);
      idle(2);
      rd_chk(ADDR_IRQ, 8'h0F, "mismatch keeps flag set");
      rd_chk(ADDR_CTRL, 8'h03, "read ends mismatch");
      wr(ADDR_IRQ, 8'h0E);
      idle(3);
      rd_chk(ADDR_IRQ, 8'h0E, "flag cleared after read");
      chk_pin(irq, 1'b0, "request drops");
      wr(ADDR_IRQ, 8'h0C);
      lvl[7:0] = 8'h0A;
      idle(6);
      chk_pin(irq, 1'b0, "no request with enable clear");
      rd_chk(ADDR_IRQ, 8'h0D, "flag still set when masked");
      wr(ADDR_CTRL, 8'h03);
      wr(ADDR_IRQ, 8'h00);
      wr(ADDR_IRQ, 8'h01);
      rd_chk(ADDR_IRQ, 8'h01, "software sets flag");
      $display("test irq done");
   endtask : test_irq

   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      idle(2);
      test_reset();
      test_modes();
      test_result();
      test_vref();
      test_irq();
      complete_run();
   end
endmodule : tb_dual_comparator_control
